// ---- design/rs485_polled_data_link.sv ----
`timescale 1ns/1ns
`include "link_map.svh"

// Functional notes
// [R1] Role is one bit, master or slave, latched between exchanges.
// [R2] Master polls stations 1 up to a count of at most 31.
// [R3] Start-stop characters at 19200, 38400 or 57600 bit/s, selectable.
// [R4] Start, seven data, even parity, stop; bad parity counts as an error.
// [R5] Exchange size is zero to six words each way.
// [R6] Master keeps thirteen words per slave: six out, six in, one status.
// [R7] Slave keeps thirteen words for the master: six out, six in, one status.
// [R8] Link runs freely; visible words change only at end of scan.
// [R9] Master sends the configured word count to the polled slave.
// [R10] Slave answers with as many words as it received.
// [R11] Master serves one slave per cycle, never overlapping.
// [R12] Master steps through all present slaves, one per cycle.
// [R13] Completion flag stands for exactly one scan after a finished cycle.
// [R14] Master outgoing words land in the slave's incoming words.
// [R15] Slave outgoing words land in the master's incoming words for it.
// [R16] Two resends after an error; third failure writes the status code.
module rs485_polled_data_link
	import link_pkg::*;
#(
	parameter int REPLY_TIMEOUT_CYC = `REPLY_TIMEOUT_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic role_master,
	input wire logic [4:0] own_station,
	input wire logic [4:0] slave_total,
	input wire logic [2:0] exch_words,
	input wire logic [1:0] baud_sel,
	input wire logic end_of_scan,
	input wire logic prog_we,
	input wire logic [8:0] prog_addr,
	input wire logic [15:0] prog_wdata,
	output logic [15:0] prog_rdata,
	output logic prog_busy,
	output logic cycle_done,
	input wire logic line_in,
	output logic line_out,
	output logic line_oe_n
);
	link_state_e state_q;
	logic role_q;
	logic [1:0] baud_q;
	logic [9:0] bit_div;
	logic [4:0] station_q;
	logic [2:0] count_q;
	logic [4:0] k_q;
	logic [1:0] part_q;
	logic [2:0] widx_q;
	logic [1:0] tries_q;
	logic [15:0] err_q;
	logic [19:0] timer_q;
	logic [2:0] ld_q;
	logic [2:0] push_q;
	logic [15:0] tx_buf_q [`MAX_WORDS];
	logic [15:0] rx_buf_q [`MAX_WORDS];
	logic [4:0] frame_len;
	logic [15:0] cur_word;
	logic [6:0] tx_char;
	logic tx_go;
	logic rx_ev;
	logic rx_data;
	logic adv;
	logic timeout;
	logic [2:0] cfg_words;
	logic [8:0] load_addr;
	logic [15:0] load_data;
	logic sync1_q, sync2_q;
	logic rx_busy_q;
	logic [9:0] rx_cnt_q;
	logic [3:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic rx_stb_q;
	logic [6:0] rx_char_q;
	logic rx_perr_q;
	logic tx_busy_q;
	logic [9:0] tx_cnt_q;
	logic [3:0] tx_bit_q;
	logic [9:0] tx_sh_q;
	logic line_out_q;
	logic line_oe_n_q;
	logic drain_q;
	logic pend_q;
	logic cycle_done_q;
	entry_s push_e;
	entry_s pop_e;
	logic mem_we;
	logic [8:0] mem_waddr;
	logic [15:0] mem_wdata;

	stream_if #(.W($bits(entry_s))) push_s ();
	stream_if #(.W($bits(entry_s))) pop_s ();

	// ----------------------------------------
	// Result queue and station memory
	// ----------------------------------------
	word_fifo #(.W($bits(entry_s)), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_s(push_s.snk),
		.out_s(pop_s.src)
	);

	word_mem #(.AW(`MEM_AW), .W(`WORD_W)) u_mem (
		.clock(clock),
		.rst_n(rst_n),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.ra_addr(prog_addr),
		.ra_data(prog_rdata),
		.rb_addr(load_addr),
		.rb_data(load_data)
	);

	// ----------------------------------------
	// Bit timing
	// ----------------------------------------
	always_comb begin
		unique case (baud_q)
			2'h0: bit_div = 10'(`BIT_DIV_LO); // [R3]
			2'h1: bit_div = 10'(`BIT_DIV_MID); // [R3]
			default: bit_div = 10'(`BIT_DIV_HI); // [R3]
		endcase
	end

	// ----------------------------------------
	// Character receiver
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= line_in;
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_busy_q <= 1'b0;
			rx_cnt_q <= '0;
			rx_bit_q <= '0;
			rx_sh_q <= '0;
			rx_stb_q <= 1'b0;
			rx_char_q <= '0;
			rx_perr_q <= 1'b0;
		end else begin
			rx_stb_q <= 1'b0;
			if (!rx_busy_q) begin
				if (!sync2_q) begin
					rx_busy_q <= 1'b1;
					rx_cnt_q <= bit_div >> 1;
					rx_bit_q <= '0;
				end
			end else if (rx_cnt_q != '0) begin
				rx_cnt_q <= rx_cnt_q - 10'h1;
			end else begin
				rx_cnt_q <= bit_div - 10'h1;
				if (rx_bit_q == 4'h0) begin
					if (sync2_q) begin
						rx_busy_q <= 1'b0;
					end else begin
						rx_bit_q <= 4'h1;
					end
				end else if (rx_bit_q != 4'h9) begin
					rx_sh_q <= {sync2_q, rx_sh_q[7:1]};
					rx_bit_q <= rx_bit_q + 4'h1;
				end else begin
					rx_busy_q <= 1'b0;
					rx_stb_q <= 1'b1;
					rx_char_q <= rx_sh_q[6:0];
					rx_perr_q <= (^rx_sh_q) | ~sync2_q; // [R4]
				end
			end
		end
	end

	// ----------------------------------------
	// Character transmitter
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy_q <= 1'b0;
			tx_cnt_q <= '0;
			tx_bit_q <= '0;
			tx_sh_q <= '1;
			line_out_q <= 1'b1;
		end else if (!tx_busy_q) begin
			line_out_q <= 1'b1;
			if (tx_go) begin
				tx_sh_q <= {1'b1, ^tx_char, tx_char, 1'b0}; // [R4]
				tx_busy_q <= 1'b1;
				tx_bit_q <= '0;
				tx_cnt_q <= bit_div - 10'h1;
				line_out_q <= 1'b0;
			end
		end else if (tx_cnt_q != '0) begin
			tx_cnt_q <= tx_cnt_q - 10'h1;
		end else begin
			tx_cnt_q <= bit_div - 10'h1;
			if (tx_bit_q == 4'h9) begin
				tx_busy_q <= 1'b0;
			end else begin
				tx_bit_q <= tx_bit_q + 4'h1;
				line_out_q <= tx_sh_q[1];
				tx_sh_q <= {1'b1, tx_sh_q[9:1]};
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			line_oe_n_q <= 1'b1;
		end else begin
			line_oe_n_q <= ~((state_q == ST_SEND) | tx_busy_q);
		end
	end

	assign line_out = line_out_q;
	assign line_oe_n = line_oe_n_q;

	// ----------------------------------------
	// Frame helpers
	// ----------------------------------------
	assign cfg_words = (exch_words > 3'(`MAX_WORDS)) ? 3'(`MAX_WORDS) : exch_words; // [R5]
	assign frame_len = 5'h2 + {1'b0, count_q, 1'b0} + {2'h0, count_q};
	assign cur_word = tx_buf_q[widx_q];
	assign load_addr = {station_q, `IDX_OUT + {1'b0, ld_q}};
	assign tx_go = (state_q == ST_SEND) && !tx_busy_q && (k_q != frame_len);
	assign rx_ev = rx_stb_q && (state_q == ST_RECV);
	assign rx_data = rx_ev && !rx_perr_q && !rx_char_q[6] && (k_q >= 5'h2);
	assign adv = tx_go | rx_data;
	assign timeout = (timer_q == 20'(REPLY_TIMEOUT_CYC - 1));

	always_comb begin
		if (k_q == 5'h0) begin
			tx_char = {1'b1, ~role_q, station_q};
		end else if (k_q == 5'h1) begin
			tx_char = {4'h0, count_q};
		end else if (part_q == 2'h0) begin
			tx_char = {1'b0, cur_word[15:10]};
		end else if (part_q == 2'h1) begin
			tx_char = {1'b0, cur_word[9:4]};
		end else begin
			tx_char = {3'h0, cur_word[3:0]};
		end
	end

	// ----------------------------------------
	// Word buffers for the frame in flight
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `MAX_WORDS; i++) begin
				tx_buf_q[i] <= '0;
				rx_buf_q[i] <= '0;
			end
		end else begin
			if (state_q == ST_LOAD && ld_q != 3'h0) begin
				tx_buf_q[ld_q - 3'h1] <= load_data; // [R14] [R15]
			end
			if (rx_data) begin
				unique case (part_q)
					2'h0: rx_buf_q[widx_q][15:10] <= rx_char_q[5:0];
					2'h1: rx_buf_q[widx_q][9:4] <= rx_char_q[5:0];
					default: rx_buf_q[widx_q][3:0] <= rx_char_q[3:0];
				endcase
			end
		end
	end

	// ----------------------------------------
	// Exchange sequencer
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			role_q <= 1'b0;
			baud_q <= 2'h0;
			station_q <= '0;
			count_q <= '0;
			k_q <= '0;
			part_q <= '0;
			widx_q <= '0;
			tries_q <= '0;
			err_q <= `ERR_NONE;
			timer_q <= '0;
			ld_q <= '0;
			push_q <= '0;
		end else begin
			if (adv) begin
				k_q <= k_q + 5'h1;
				if (k_q >= 5'h2) begin
					if (part_q == 2'h2) begin
						part_q <= 2'h0;
						widx_q <= widx_q + 3'h1;
					end else begin
						part_q <= part_q + 2'h1;
					end
				end
			end
			unique case (state_q)
				ST_IDLE: begin
					role_q <= role_master; // [R1]
					baud_q <= baud_sel;
					err_q <= `ERR_NONE;
					timer_q <= '0;
					k_q <= '0;
					part_q <= '0;
					widx_q <= '0;
					ld_q <= '0;
					if (role_master) begin
						if (slave_total != 5'h0) begin
							count_q <= cfg_words; // [R5] [R9]
							if (station_q == 5'h0 || station_q >= slave_total ||
									station_q >= 5'(`MAX_SLAVES)) begin
								station_q <= 5'h1; // [R2] [R12]
							end else begin
								station_q <= station_q + 5'h1; // [R12]
							end
							state_q <= ST_LOAD;
						end
					end else begin
						station_q <= own_station;
						state_q <= ST_RECV;
					end
				end
				ST_LOAD: begin
					ld_q <= ld_q + 3'h1;
					if (ld_q == 3'(`MAX_WORDS)) begin
						k_q <= '0;
						part_q <= '0;
						widx_q <= '0;
						state_q <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (!tx_busy_q && !tx_go) begin
						k_q <= '0;
						part_q <= '0;
						widx_q <= '0;
						timer_q <= '0;
						push_q <= '0;
						state_q <= role_q ? ST_RECV : ST_PUSH; // [R10] [R11]
					end
				end
				ST_RECV: begin
					if (!role_q && k_q == 5'h0) begin
						timer_q <= '0;
					end else if (!timeout) begin
						timer_q <= timer_q + 20'h1;
					end
					if (rx_ev) begin
						timer_q <= '0;
						if (rx_perr_q) begin
							if (role_q || k_q != 5'h0) begin
								err_q <= `ERR_PARITY; // [R4]
								state_q <= ST_FAIL;
							end
						end else if (!role_q && rx_char_q[6]) begin
							k_q <= (rx_char_q == {2'h2, station_q}) ? 5'h1 : 5'h0;
							part_q <= '0;
							widx_q <= '0;
						end else if (role_q && k_q == 5'h0) begin
							if (rx_char_q == {2'h3, station_q}) begin
								k_q <= 5'h1;
							end else begin
								err_q <= `ERR_FRAME;
								state_q <= ST_FAIL;
							end
						end else if (k_q == 5'h1) begin
							if (rx_char_q[6:3] != 4'h0 || rx_char_q[2:0] > 3'(`MAX_WORDS) ||
									(role_q && rx_char_q[2:0] != count_q)) begin
								err_q <= `ERR_FRAME; // [R10]
								state_q <= ST_FAIL;
							end else begin
								count_q <= rx_char_q[2:0]; // [R10]
								k_q <= 5'h2;
								if (rx_char_q[2:0] == 3'h0) begin
									push_q <= '0;
									ld_q <= '0;
									state_q <= role_q ? ST_PUSH : ST_LOAD;
								end
							end
						end else if (role_q && rx_char_q[6]) begin
							err_q <= `ERR_FRAME;
							state_q <= ST_FAIL;
						end else if (rx_data && k_q == frame_len - 5'h1) begin
							push_q <= '0;
							ld_q <= '0;
							state_q <= role_q ? ST_PUSH : ST_LOAD; // [R10]
						end
					end else if (timeout) begin
						err_q <= `ERR_TIMEOUT;
						state_q <= ST_FAIL;
					end
				end
				ST_FAIL: begin
					k_q <= '0;
					part_q <= '0;
					widx_q <= '0;
					timer_q <= '0;
					if (tries_q == 2'(`TRIES - 1)) begin
						tries_q <= '0;
						push_q <= count_q;
						state_q <= ST_PUSH; // [R16]
					end else begin
						tries_q <= tries_q + 2'h1; // [R16]
						err_q <= `ERR_NONE;
						state_q <= role_q ? ST_SEND : ST_RECV;
					end
				end
				ST_PUSH: begin
					if (push_s.valid && push_s.ready) begin
						if (push_e.last) begin
							if (err_q == `ERR_NONE) begin
								tries_q <= '0;
							end
							state_q <= ST_IDLE; // [R11]
						end else begin
							push_q <= push_q + 3'h1;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Results toward the program side
	// ----------------------------------------
	always_comb begin
		push_e = '0;
		push_e.station = station_q;
		if (push_q < count_q && err_q == `ERR_NONE) begin
			push_e.idx = `IDX_IN + {1'b0, push_q}; // [R6] [R7]
			push_e.data = rx_buf_q[push_q];
		end else begin
			push_e.idx = `IDX_STATUS; // [R6] [R7] [R16]
			push_e.data = err_q;
			push_e.last = 1'b1;
		end
	end

	assign push_s.valid = (state_q == ST_PUSH) && !drain_q;
	assign push_s.data = push_e;
	assign pop_e = entry_s'(pop_s.data);
	assign pop_s.ready = drain_q;

	assign mem_we = drain_q ? pop_s.valid : prog_we;
	assign mem_waddr = drain_q ? {pop_e.station, pop_e.idx} : prog_addr; // [R8]
	assign mem_wdata = drain_q ? pop_e.data : prog_wdata;

	// ----------------------------------------
	// End of scan refresh
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			drain_q <= 1'b0;
			pend_q <= 1'b0;
			cycle_done_q <= 1'b0;
		end else if (!drain_q) begin
			if (end_of_scan) begin
				drain_q <= 1'b1; // [R8]
			end
		end else if (!pop_s.valid) begin
			drain_q <= 1'b0;
			cycle_done_q <= pend_q; // [R13]
			pend_q <= 1'b0;
		end else if (pop_e.last) begin
			pend_q <= 1'b1; // [R13]
		end
	end

	assign prog_busy = drain_q;
	assign cycle_done = cycle_done_q;
endmodule : rs485_polled_data_link

// ---- design/link_map.svh ----
`ifndef LINK_MAP_SVH
`define LINK_MAP_SVH

// ----------------------------------------
// Clock and line rates
// ----------------------------------------
`define CLK_HZ 10000000
`define BAUD_LO 19200
`define BAUD_MID 38400
`define BAUD_HI 57600
`define BIT_DIV_LO (`CLK_HZ / `BAUD_LO)
`define BIT_DIV_MID (`CLK_HZ / `BAUD_MID)
`define BIT_DIV_HI (`CLK_HZ / `BAUD_HI)

// ----------------------------------------
// Link sizes
// ----------------------------------------
`define MAX_SLAVES 31
`define MAX_WORDS 6
`define TRIES 3
`define FIFO_DEPTH 32
`define WORD_W 16
`define MEM_AW 9

// ----------------------------------------
// Word index inside a station set
// ----------------------------------------
`define IDX_OUT 4'h0
`define IDX_IN 4'h6
`define IDX_STATUS 4'hc

// ----------------------------------------
// Reply timeout
// ----------------------------------------
`define REPLY_TIMEOUT_US 5000
`define REPLY_TIMEOUT_CYC (`REPLY_TIMEOUT_US * (`CLK_HZ / 1000000))

// ----------------------------------------
// Status word codes
// ----------------------------------------
`define ERR_NONE 16'h0000
`define ERR_PARITY 16'h0001
`define ERR_TIMEOUT 16'h0002
`define ERR_FRAME 16'h0003

`endif

// ---- design/link_pkg.sv ----
package link_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_LOAD = 3'h1,
		ST_SEND = 3'h2,
		ST_RECV = 3'h3,
		ST_FAIL = 3'h4,
		ST_PUSH = 3'h5
	} link_state_e;

	typedef struct packed {
		logic last;
		logic [4:0] station;
		logic [3:0] idx;
		logic [15:0] data;
	} entry_s;

endpackage : link_pkg

// ---- design/stream_if.sv ----
`timescale 1ns/1ns
interface stream_if #(
	parameter int W = 26
);
	logic valid;
	logic ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : stream_if

// ---- design/word_fifo.sv ----
`timescale 1ns/1ns
module word_fifo #(
	parameter int W = 26,
	parameter int DEPTH = 32
) (
	input wire logic clock,
	input wire logic rst_n,
	stream_if.snk in_s,
	stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0] wp_q;
	logic [AW:0] rp_q;
	logic full;
	logic empty;

	assign empty = (wp_q == rp_q);
	assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign in_s.ready = ~full;
	assign out_s.valid = ~empty;
	assign out_s.data = mem_q[rp_q[AW-1:0]];

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (in_s.valid && !full) begin
			mem_q[wp_q[AW-1:0]] <= in_s.data;
		end
	end

	// ----------------------------------------
	// Pointers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (in_s.valid && !full) begin
				wp_q <= wp_q + 1'b1;
			end
			if (out_s.ready && !empty) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule : word_fifo

// ---- design/word_mem.sv ----
`timescale 1ns/1ns
module word_mem #(
	parameter int AW = 9,
	parameter int W = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] ra_addr,
	output logic [W-1:0] ra_data,
	input wire logic [AW-1:0] rb_addr,
	output logic [W-1:0] rb_data
);
	logic [W-1:0] mem_q [2**AW];

	always_ff @(posedge clock) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ra_data <= '0;
			rb_data <= '0;
		end else begin
			ra_data <= mem_q[ra_addr];
			rb_data <= mem_q[rb_addr];
		end
	end
endmodule : word_mem

// ---- verif/rs485_polled_data_link_asserts.sv ----
`timescale 1ns/1ns
`include "link_map.svh"
// ----
// Link checker
// ----
module rs485_polled_data_link_asserts
	import link_pkg::*;
#(
	parameter int REPLY_TIMEOUT_CYC = 2000
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [1:0] baud_sel,
	input wire logic end_of_scan,
	input wire logic prog_we,
	input wire logic [8:0] prog_addr,
	input wire logic [15:0] prog_wdata,
	input wire logic [15:0] prog_rdata,
	input wire logic prog_busy,
	input wire logic cycle_done,
	input wire logic line_out,
	input wire logic line_oe_n
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	int low_q;
	int bit_div;
	assign bit_div = (baud_sel == 2'h0) ? `BIT_DIV_LO : (baud_sel == 2'h1) ? `BIT_DIV_MID : `BIT_DIV_HI;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			low_q <= 0;
		end else begin
			low_q <= line_out ? 0 : low_q + 1;
		end
	end
	property p_idle_level;
		line_oe_n |-> line_out;
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("line low while released");
	property p_bit_time;
		$rose(line_out) && !line_oe_n |-> (low_q % bit_div) == 0;
	endproperty
	a_bit_time: assert property (p_bit_time) else $error("low run not whole bits");
	property p_drive_span;
		$fell(line_oe_n) |-> !line_oe_n [*8];
	endproperty
	a_drive_span: assert property (p_drive_span) else $error("driver burst too short");
	property p_refresh_start;
		end_of_scan && !prog_busy |=> prog_busy;
	endproperty
	a_refresh_start: assert property (p_refresh_start) else $error("refresh not started");
	property p_refresh_bound;
		$rose(prog_busy) |-> ##[1:40] !prog_busy;
	endproperty
	a_refresh_bound: assert property (p_refresh_bound) else $error("refresh too long");
	property p_done_moment;
		$changed(cycle_done) |-> $fell(prog_busy);
	endproperty
	a_done_moment: assert property (p_done_moment) else $error("done flag moved off refresh end");
	property p_reset_quiet;
		$rose(rst_n) |-> !cycle_done && !prog_busy && line_oe_n;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
	property p_read_back;
		(prog_we && !prog_busy) ##1 (prog_addr == $past(prog_addr) && !prog_busy && !prog_we)
			|=> prog_rdata == $past(prog_wdata, 2);
	endproperty
	a_read_back: assert property (p_read_back) else $error("read back differs");
	c_done: cover property ($rose(cycle_done));
	c_refresh: cover property ($rose(prog_busy));
	c_drive: cover property ($fell(line_oe_n));
endmodule : rs485_polled_data_link_asserts

bind rs485_polled_data_link rs485_polled_data_link_asserts #(.REPLY_TIMEOUT_CYC(REPLY_TIMEOUT_CYC)) u_asserts (
	.clock(clock), .rst_n(rst_n), .baud_sel(baud_sel), .end_of_scan(end_of_scan), .prog_we(prog_we),
	.prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .prog_busy(prog_busy),
	.cycle_done(cycle_done), .line_out(line_out), .line_oe_n(line_oe_n));

// ---- verif/link_slave_model.sv ----
`timescale 1ns/1ns
// ----
// Slave station model
// ----
module link_slave_model #(
	parameter int BIT = 173,
	parameter logic [4:0] STATION = 5'h01
) (
	input wire logic clock,
	input wire logic line,
	output logic tx,
	output logic drive
);
	int mute_left = 0;
	int frames = 0;
	int gap = 20;
	int got_n = 0;
	logic [15:0] out_w [0:5];
	logic [15:0] got_w [0:5];
	task automatic rx_char(output logic [7:0] c, inout logic bad);
		while (line !== 1'b0) @(posedge clock);
		repeat (BIT / 2) @(posedge clock);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge clock);
			if (i < 8) c[i] = line;
			else if (line !== 1'b1) bad = 1'b1;
		end
		if (^c !== 1'b0) bad = 1'b1;
	endtask : rx_char
	task automatic tx_char(input logic [6:0] d);
		logic [9:0] f;
		f = {1'b1, ^d, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			tx <= f[i];
			repeat (BIT) @(posedge clock);
		end
	endtask : tx_char
	initial begin
		logic [7:0] h, c, a, b, d;
		logic bad;
		tx = 1'b1;
		drive = 1'b0;
		forever begin
			bad = 1'b0;
			rx_char(h, bad);
			if (bad || h[6:0] !== {2'b10, STATION}) continue;
			rx_char(c, bad);
			got_n = c[2:0];
			for (int w = 0; w < got_n; w++) begin
				rx_char(a, bad);
				rx_char(b, bad);
				rx_char(d, bad);
				got_w[w] = {a[5:0], b[5:0], d[3:0]};
			end
			frames++;
			if (bad) continue;
			if (mute_left > 0) begin
				mute_left--;
				continue;
			end
			repeat (gap) @(posedge clock);
			drive <= 1'b1;
			tx_char({2'b11, STATION});
			tx_char({4'h0, c[2:0]});
			for (int w = 0; w < got_n; w++) begin
				tx_char({1'b0, out_w[w][15:10]});
				tx_char({1'b0, out_w[w][9:4]});
				tx_char({3'h0, out_w[w][3:0]});
			end
			drive <= 1'b0;
		end
	end
endmodule : link_slave_model

// ---- verif/test_rs485_polled_data_link.sv ----
`timescale 1ns/1ns
`include "link_map.svh"
// ----
// Master bench
// ----
module test_rs485_polled_data_link
	import link_pkg::*;
;
	localparam int LIMIT = 100000;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] slave_total = 5'h00;
	logic [2:0] exch_words = 3'h2;
	logic end_of_scan = 1'b0;
	logic prog_we = 1'b0;
	logic [8:0] prog_addr = 9'h000;
	logic [15:0] prog_wdata = 16'h0000;
	logic [15:0] prog_rdata, rd;
	logic prog_busy, cycle_done, line_in, line_out, line_oe_n, slv_tx, slv_drive;
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int oe_falls = 0;
	int seed, f0;
	logic [15:0] exp_out [0:5];
	assign line_in = !line_oe_n ? line_out : (slv_drive ? slv_tx : 1'b1);
	rs485_polled_data_link #(.REPLY_TIMEOUT_CYC(2000)) DUT (.clock(clock), .rst_n(rst_n), .role_master(1'b1),
		.own_station(5'h00), .slave_total(slave_total), .exch_words(exch_words), .baud_sel(2'h2),
		.end_of_scan(end_of_scan), .prog_we(prog_we), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
		.prog_rdata(prog_rdata), .prog_busy(prog_busy), .cycle_done(cycle_done), .line_in(line_in),
		.line_out(line_out), .line_oe_n(line_oe_n));
	link_slave_model #(.BIT(`BIT_DIV_HI), .STATION(5'h01)) partner (.clock(clock), .line(line_in),
		.tx(slv_tx), .drive(slv_drive));
	initial begin
		forever #50 clock = ~clock;
	end
	always @(negedge line_oe_n) oe_falls++;
	always @(posedge clock) begin
		cyc++;
		if (cyc == LIMIT) begin
			fail_count++;
			$display("MISMATCH run_cycles expected %0d seen %0d", LIMIT - 1, cyc);
			conclude();
		end
	end
	task automatic conclude();
		$display("Counts: %0d checks, %0d mismatches", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude
	task automatic cmp_word(input string what, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_word
	task automatic cmp_flag(input string what, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %b seen %b", what, e, g);
		end
	endtask : cmp_flag
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#10;
	endtask : tick
	task automatic scan();
		end_of_scan = 1'b1;
		tick(1);
		end_of_scan = 1'b0;
		cmp_flag("refresh_busy", 1'b1, prog_busy);
		for (int k = 0; k < 60 && prog_busy !== 1'b0; k++) tick(1);
	endtask : scan
	task automatic wr(input logic [8:0] a, input logic [15:0] v);
		prog_addr = a;
		prog_wdata = v;
		prog_we = 1'b1;
		tick(1);
		prog_we = 1'b0;
		tick(1);
	endtask : wr
	task automatic rd_word(input logic [8:0] a);
		prog_addr = a;
		tick(1);
		rd = prog_rdata;
	endtask : rd_word
	task automatic run_frames(input int n);
		slave_total = 5'h01;
		for (int k = 0; k < 400 && partner.frames < n; k++) begin
			tick(300);
			scan();
		end
		slave_total = 5'h00;
		for (int k = 0; k < 80 && cycle_done !== 1'b1; k++) begin
			tick(300);
			scan();
		end
		cmp_flag("cycle_done_set", 1'b1, cycle_done);
	endtask : run_frames
	task automatic close_test(input string name);
		scan();
		cmp_flag("cycle_done_clear", 1'b0, cycle_done);
		$display("Test %s done", name);
	endtask : close_test
	initial begin
		seed = $urandom(91);
		repeat (20) @(posedge clock);
		#10;
		rst_n = 1'b1;
		tick(1);
		cmp_flag("line_out", 1'b1, line_out);
		cmp_flag("line_oe_n", 1'b1, line_oe_n);
		tick(2000);
		cmp_word("idle_drives", 16'h0000, 16'(oe_falls));
		$display("Test idle done");
		for (int i = 0; i < 6; i++) begin
			exp_out[i] = 16'($urandom);
			partner.out_w[i] = 16'($urandom);
			wr({5'h01, 4'(`IDX_OUT + i)}, exp_out[i]);
		end
		rd_word({5'h01, `IDX_OUT});
		cmp_word("out_word", exp_out[0], rd);
		partner.gap = 20 + ($urandom % 400);
		run_frames(1);
		cmp_word("sent_count", 16'h0002, 16'(partner.got_n));
		for (int i = 0; i < 2; i++) begin
			cmp_word("slave_in", exp_out[i], partner.got_w[i]);
			rd_word({5'h01, 4'(`IDX_IN + i)});
			cmp_word("master_in", partner.out_w[i], rd);
		end
		rd_word({5'h01, `IDX_STATUS});
		cmp_word("status_ok", `ERR_NONE, rd);
		close_test("exchange");
		exch_words = 3'h0;
		partner.mute_left = 3;
		f0 = partner.frames;
		run_frames(f0 + 3);
		rd_word({5'h01, `IDX_STATUS});
		cmp_word("status_fail", `ERR_TIMEOUT, rd);
		cmp_word("tries_fail", 16'(`TRIES), 16'(partner.frames - f0));
		close_test("three_failures");
		partner.mute_left = 2;
		f0 = partner.frames;
		run_frames(f0 + 3);
		rd_word({5'h01, `IDX_STATUS});
		cmp_word("status_retry", `ERR_NONE, rd);
		cmp_word("tries_retry", 16'h0003, 16'(partner.frames - f0));
		cmp_word("empty_count", 16'h0000, 16'(partner.got_n));
		close_test("retry_success");
		conclude();
	end
endmodule : test_rs485_polled_data_link
